// [rtl/rwc_consts.svh]
`ifndef RWC_CONSTS_SVH
`define RWC_CONSTS_SVH
// Contract
// - Internal reset reloads registers, restarts at vector
// - Port reset follows any active source
// - Stretch reset by fuse-selected time-out
// - Five sources: power, pin, watchdog, brown-out, debug
// - Pin low past minimum width causes reset
// - Pin release starts delay counter
// - Power-on holds reset, reasserts at once
// - Enabled brown-out resets at once, stretched release
// - Level fuse selects brown-out trigger level
// - Brown-out ignores dips shorter than filter
// - Debug reset holds while scan bit is one
// - Watchdog expiry gives one-cycle pulse, then stretch
// - Watchdog counts its own 1 MHz oscillator
// - Restart, disable, chip reset clear watchdog counter
// - Eight periods; expiry without restart resets
// - Disabled watchdog never resets
// - Bandgap on for brown-out, comparator or converter
// - Turn-off enable self-clears after four clocks
// - Prescale code selects 16384 doubling to 2097152
// - Per-source flags; power flag cleared by software only

// Register byte offsets
`define RWC_ADR_FLAGS 4'h0
`define RWC_ADR_WDT 4'h4
`define RWC_ADR_ACMP 4'h8
// Clock period in ps and timing figures in ns
`define RWC_CLK_PS 8000
`define RWC_EXT_MIN_NS 1500
`define RWC_BOD_FILTER_NS 2000
`define RWC_TOUT_SHORT_NS 4100
`define RWC_TOUT_LONG_NS 65000000
// Watchdog figures
`define RWC_WDT_BASE 16384
`define RWC_TOE_CLOCKS 3'h4
`endif

// [rtl/rwc_pkg.sv]
package rwc_pkg;
    // Reset cause flags, software visible
    typedef struct packed {
        logic debug;
        logic wdt;
        logic brownout_detector;
        logic ext;
        logic por;
    } rwc_flags_t;
    // Watchdog control fields
    typedef struct packed {
        logic toe;
        logic enable;
        logic [2:0] prescale;
    } rwc_wdt_ctl_t;
    typedef enum logic [1:0] {SEQ_HOLD, SEQ_STRETCH, SEQ_RUN} rwc_seq_t;
endpackage

// [rtl/rwc_top.sv]
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rwc_consts.svh"
module rwc_top import rwc_pkg::*; #(
    // Reckoned in whole nanoseconds: the picosecond product would overflow int
    parameter int TOUT_LONG_CYC = (`RWC_TOUT_LONG_NS + `RWC_CLK_PS / 1000 - 1)
        / (`RWC_CLK_PS / 1000),
    parameter int WDT_BASE = `RWC_WDT_BASE
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Reset sources and fuses
    input wire logic power_low_i,
    input wire logic reset_pin_n_i,
    input wire logic supply_below_bot_lo_i,
    input wire logic supply_above_bot_hi_i,
    input wire logic debug_reset_reg_i,
    input wire logic brownout_enable_fuse_i,
    input wire logic brownout_level_fuse_i,
    input wire logic [1:0] clock_select_fuses_i,
    input wire logic adc_enable_i,
    input wire logic watchdog_restart_instruction_i,
    input wire logic wdt_osc_i,
    // Outputs
    output logic internal_reset_o,
    output logic port_reset_o,
    output logic brownout_level_high_o,
    output logic bandgap_enable_o
);
    function automatic int cyc_ceil(input int ns);
        int c;
        c = (ns * 1000 + `RWC_CLK_PS - 1) / `RWC_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Filter widths rounded up so a pulse is never judged too long
    localparam int EXT_MIN_CYC = cyc_ceil(`RWC_EXT_MIN_NS);
    localparam int BOD_CYC = cyc_ceil(`RWC_BOD_FILTER_NS);
    localparam int TOUT_SHORT_CYC = cyc_ceil(`RWC_TOUT_SHORT_NS);

    // Fuse code 00 stretches by one cycle, 01 short, 1x long
    function automatic logic [23:0] tout_cycles(input logic [1:0] sel);
        logic [23:0] v;
        v = 24'h000001;
        if (sel == 2'h1) begin
            v = 24'(TOUT_SHORT_CYC);
        end else if (sel[1]) begin
            v = 24'(TOUT_LONG_CYC);
        end
        return v;
    endfunction

    logic ext_src_r, bod_src_r, wdt_pulse_r;
    logic [15:0] ext_cnt_r, bod_cnt_r;
    logic sync1_r, sync2_r, any_src;
    logic [23:0] tout_cnt_r;
    rwc_seq_t seq_r;
    logic internal_reset_r;
    rwc_flags_t flags_r;
    rwc_wdt_ctl_t wdt_ctl_r;
    logic [2:0] toe_cnt_r;
    logic cmp_bg_sel_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic wr_en, wr_lane0;
    logic osc_s1_r, osc_s2_r, osc_s3_r, osc_tick;
    logic [21:0] wdt_cnt_r;
    logic [21:0] wdt_limit;

    // Pin reset only after the low level outlasts the minimum width
    always_ff @(posedge clk_i) begin
        if (rst_i || reset_pin_n_i) begin
            ext_cnt_r <= '0;
            ext_src_r <= 1'b0;
        end else if (ext_cnt_r >= 16'(EXT_MIN_CYC - 1)) begin
            ext_src_r <= 1'b1;
        end else begin
            ext_cnt_r <= ext_cnt_r + 16'h0001;
        end
    end

    // Brown-out: filtered on the way in, released only above upper level
    always_ff @(posedge clk_i) begin
        if (rst_i || !brownout_enable_fuse_i) begin
            bod_cnt_r <= '0;
            bod_src_r <= 1'b0;
        end else if (bod_src_r) begin
            if (supply_above_bot_hi_i) begin
                bod_src_r <= 1'b0;
                bod_cnt_r <= '0;
            end
        end else if (!supply_below_bot_lo_i) begin
            bod_cnt_r <= '0;
        end else if (bod_cnt_r >= 16'(BOD_CYC - 1)) begin
            bod_src_r <= 1'b1;
        end else begin
            bod_cnt_r <= bod_cnt_r + 16'h0001;
        end
    end

    // Level fuse is passed to the analog comparator as its threshold pick
    always_ff @(posedge clk_i) begin
        brownout_level_high_o <= brownout_level_fuse_i;
    end

    // All five sources combine by OR
    assign any_src = power_low_i | ext_src_r | bod_src_r | wdt_pulse_r
                   | debug_reset_reg_i;

    // Port reset follows sources one edge later; needs the clock running
    always_ff @(posedge clk_i) begin
        port_reset_o <= rst_i | any_src;
    end

    // Two-flop release synchroniser; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= any_src;
            sync2_r <= sync1_r;
        end
    end

    // Stretch sequencer: any source back restarts the count from zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= SEQ_HOLD;
            tout_cnt_r <= '0;
            internal_reset_r <= 1'b1;
        end else begin
            unique case (seq_r)
                SEQ_HOLD: begin
                    tout_cnt_r <= '0;
                    internal_reset_r <= 1'b1;
                    if (!sync2_r) begin
                        seq_r <= SEQ_STRETCH;
                    end
                end
                SEQ_STRETCH: begin
                    if (sync2_r) begin
                        seq_r <= SEQ_HOLD;
                        tout_cnt_r <= '0;
                    end else if (tout_cnt_r >= tout_cycles(clock_select_fuses_i) - 24'h1) begin
                        seq_r <= SEQ_RUN;
                        internal_reset_r <= 1'b0;
                    end else begin
                        tout_cnt_r <= tout_cnt_r + 24'h000001;
                    end
                end
                SEQ_RUN: begin
                    if (sync2_r) begin
                        seq_r <= SEQ_HOLD;
                        internal_reset_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Core restarts from the vector when this falls
    assign internal_reset_o = internal_reset_r;

    // Bus handshake: ack one cycle after request, dropped the next
    assign wr_en = cyc_i & stb_i & we_i & ack_r;
    assign wr_lane0 = wr_en & sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
        end
    end

    // Read data captured with the ack; unmapped words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= '0;
        end else if (cyc_i && stb_i && !ack_r) begin
            unique case (adr_i)
                `RWC_ADR_FLAGS: dat_r <= 32'(flags_r);
                `RWC_ADR_WDT: dat_r <= 32'(wdt_ctl_r);
                `RWC_ADR_ACMP: dat_r <= 32'(cmp_bg_sel_r);
                default: dat_r <= '0;
            endcase
        end
    end
    assign dat_o = dat_r;
    assign ack_o = ack_r;

    // Cause flags: hardware set wins over a software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= '0;
        end else begin
            if (wr_lane0 && adr_i == `RWC_ADR_FLAGS) begin
                flags_r <= flags_r & rwc_flags_t'(dat_i[4:0]);
            end
            if (power_low_i) begin
                flags_r.debug <= 1'b0;
                flags_r.wdt <= 1'b0;
                flags_r.brownout_detector <= 1'b0;
                flags_r.ext <= 1'b0;
                flags_r.por <= 1'b1;
            end else begin
                if (debug_reset_reg_i) flags_r.debug <= 1'b1;
                if (wdt_pulse_r) flags_r.wdt <= 1'b1;
                if (bod_src_r) flags_r.brownout_detector <= 1'b1;
                if (ext_src_r) flags_r.ext <= 1'b1;
            end
        end
    end

    // Watchdog control with protected turn-off
    always_ff @(posedge clk_i) begin
        if (rst_i || internal_reset_r) begin
            wdt_ctl_r <= '0;
            toe_cnt_r <= '0;
        end else if (wr_lane0 && adr_i == `RWC_ADR_WDT) begin
            // Prescale is taken on every write, whatever the enable does
            wdt_ctl_r.prescale <= dat_i[2:0];
            if (dat_i[4] && dat_i[3]) begin
                wdt_ctl_r.toe <= 1'b1;
                wdt_ctl_r.enable <= 1'b1;
                toe_cnt_r <= `RWC_TOE_CLOCKS;
            end else begin
                // Plain clear of the enable is ignored without turn-off enable
                wdt_ctl_r.enable <= dat_i[3] | (wdt_ctl_r.enable & ~wdt_ctl_r.toe);
                wdt_ctl_r.toe <= 1'b0;
                toe_cnt_r <= '0;
            end
        end else if (toe_cnt_r != 3'h0) begin
            toe_cnt_r <= toe_cnt_r - 3'h1;
            if (toe_cnt_r == 3'h1) begin
                wdt_ctl_r.toe <= 1'b0;
            end
        end
    end

    // Comparator bandgap select bit
    always_ff @(posedge clk_i) begin
        if (rst_i || internal_reset_r) begin
            cmp_bg_sel_r <= 1'b0;
        end else if (wr_lane0 && adr_i == `RWC_ADR_ACMP) begin
            cmp_bg_sel_r <= dat_i[0];
        end
    end

    // Bandgap powered only when some user needs it; start-up is software's wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bandgap_enable_o <= 1'b0;
        end else begin
            // A plain OR: the reference has no start-up gating of its own
            bandgap_enable_o <= brownout_enable_fuse_i | cmp_bg_sel_r | adc_enable_i;
        end
    end

    // Oscillator synchronised, rising edge seen after the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else begin
            osc_s1_r <= wdt_osc_i;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end
    // Only settled stages feed the edge detector
    assign osc_tick = osc_s2_r & ~osc_s3_r;

    // Period doubles per prescale step
    assign wdt_limit = 22'(WDT_BASE) << wdt_ctl_r.prescale;

    // Watchdog counter and expiry pulse of one system clock
    always_ff @(posedge clk_i) begin
        if (rst_i || internal_reset_r || !wdt_ctl_r.enable || watchdog_restart_instruction_i) begin
            wdt_cnt_r <= '0;
            wdt_pulse_r <= 1'b0;
        end else if (wdt_pulse_r) begin
            wdt_pulse_r <= 1'b0;
        end else if (osc_tick) begin
            if (wdt_cnt_r >= wdt_limit - 22'h1) begin
                wdt_cnt_r <= '0;
                wdt_pulse_r <= 1'b1;
            end else begin
                wdt_cnt_r <= wdt_cnt_r + 22'h1;
            end
        end
    end
endmodule

// [tb/rwc_top_asserts.sv]
`timescale 1ns/1ps
module rwc_top_asserts import rwc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic power_low_i,
    input wire logic debug_reset_reg_i,
    input wire logic brownout_enable_fuse_i,
    input wire logic brownout_level_fuse_i,
    input wire logic adc_enable_i,
    input wire logic internal_reset_o,
    input wire logic port_reset_o,
    input wire logic brownout_level_high_o,
    input wire logic bandgap_enable_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus answers exactly one cycle after a request is taken
    property p_ack_lat; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    // Source latency is three edges: two sync stages, then the sequencer register
    property p_por; $rose(power_low_i) |-> ##3 internal_reset_o; endproperty
    a_por: assert property (p_por) else $error("power low did not reset");
    property p_debug; debug_reset_reg_i |-> ##3 internal_reset_o; endproperty
    a_debug: assert property (p_debug) else $error("debug bit did not reset");
    property p_port; power_low_i || debug_reset_reg_i |=> port_reset_o; endproperty
    a_port: assert property (p_port) else $error("port reset missed a source");
    property p_bg; brownout_enable_fuse_i || adc_enable_i |=> bandgap_enable_o; endproperty
    a_bg: assert property (p_bg) else $error("bandgap off while needed");
    property p_lvl; 1'b1 |=> brownout_level_high_o == $past(brownout_level_fuse_i); endproperty
    a_lvl: assert property (p_lvl) else $error("level select wrong");
    // Release needs the sources gone through the whole pipeline
    property p_hold;
        $fell(internal_reset_o) |-> !$past(power_low_i, 3) && !$past(debug_reset_reg_i, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("reset released too early");
    c_bus: cover property (cyc_i && stb_i && ack_o);
    c_rel: cover property ($fell(internal_reset_o));
    c_bg: cover property ($rose(bandgap_enable_o));
endmodule
bind rwc_top rwc_top_asserts rwc_top_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .power_low_i(power_low_i),
    .debug_reset_reg_i(debug_reset_reg_i), .brownout_enable_fuse_i(brownout_enable_fuse_i),
    .brownout_level_fuse_i(brownout_level_fuse_i), .adc_enable_i(adc_enable_i),
    .internal_reset_o(internal_reset_o), .port_reset_o(port_reset_o),
    .brownout_level_high_o(brownout_level_high_o), .bandgap_enable_o(bandgap_enable_o));

// [tb/rwc_top_tb.sv]
`timescale 1ns/1ps
module rwc_top_tb;
    import rwc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wdt_osc_i = 0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, internal_reset_o, port_reset_o, brownout_level_high_o, bandgap_enable_o;
    logic power_low_i = 0, reset_pin_n_i = 1, below_i = 0, above_i = 1, debug_i = 0;
    logic bod_fuse_i = 0, lvl_fuse_i = 1, adc_enable_i = 0, restart_i = 0;
    logic [1:0] fuse_sel_i = 2'h0;
    int mismatches = 0, checks_done = 0, osc_cnt = 0, n, lat;
    always #4 clk_i = ~clk_i;
    // Watchdog oscillator near 1 MHz, stepped on system edges to stay race free
    always @(posedge clk_i) begin
        osc_cnt <= (osc_cnt == 61) ? 0 : osc_cnt + 1;
        if (osc_cnt == 61) wdt_osc_i <= ~wdt_osc_i;
    end
    rwc_top #(.TOUT_LONG_CYC(20), .WDT_BASE(4)) rwc_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .power_low_i(power_low_i),
        .reset_pin_n_i(reset_pin_n_i), .supply_below_bot_lo_i(below_i),
        .supply_above_bot_hi_i(above_i), .debug_reset_reg_i(debug_i),
        .brownout_enable_fuse_i(bod_fuse_i), .brownout_level_fuse_i(lvl_fuse_i),
        .clock_select_fuses_i(fuse_sel_i), .adc_enable_i(adc_enable_i),
        .watchdog_restart_instruction_i(restart_i), .wdt_osc_i(wdt_osc_i),
        .internal_reset_o(internal_reset_o), .port_reset_o(port_reset_o),
        .brownout_level_high_o(brownout_level_high_o), .bandgap_enable_o(bandgap_enable_o));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Classic single cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1);
        rd = dat_o;
        // Ack comes one cycle after the request is taken
        check("ack latency", k, 2);
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
        bus(0, a, 32'h0);
        check(what, rd, exp);
    endtask
    task automatic wait_low;
        int k;
        k = 0;
        while (internal_reset_o !== 1'b0 && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        lat = k;
        check("reset release", internal_reset_o, 0);
    endtask
    // Drive one source: 0 debug, 1 pin, 2 brown-out, 3 power
    task automatic cause(input int s, input int len, input logic [31:0] f);
        @(posedge clk_i);
        debug_i <= (s == 0);
        reset_pin_n_i <= (s != 1);
        below_i <= (s == 2);
        above_i <= (s != 2);
        power_low_i <= (s == 3);
        repeat (len) @(posedge clk_i);
        // A brown-out dip shorter than the filter must reach neither reset
        check("port reset", port_reset_o, s != 2 || len > 250);
        check("reset held", internal_reset_o, s != 2 || len > 250);
        // Idle levels: pin high, supply above both brown-out levels
        {debug_i, reset_pin_n_i, below_i, above_i, power_low_i} <= 5'h0A;
        repeat (5) @(posedge clk_i);
        wait_low();
        rdchk(4'h0, f, "flags");
        bus(1, 4'h0, 32'h0);
        $display("source %0d test done", s);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        cause(3, 5, 32'h01);
        rdchk(4'h4, 32'h0, "wdt after reset");
        rdchk(4'hC, 32'h0, "unmapped");
        cause(0, 10, 32'h10);
        check("stretch one", lat, 32'h0);
        // Release lags the pipeline by the fuse-selected count less one edge
        fuse_sel_i <= 2'h1;
        cause(0, 10, 32'h10);
        check("stretch short", lat, 32'h200);
        fuse_sel_i <= 2'h2;
        cause(0, 10, 32'h10);
        check("stretch long", lat, 32'h13);
        fuse_sel_i <= 2'h0;
        cause(1, 200, 32'h02);
        bod_fuse_i <= 1;
        cause(2, 100, 32'h0);
        cause(2, 300, 32'h04);
        bod_fuse_i <= 0;
        lvl_fuse_i <= 0;
        repeat (3) @(posedge clk_i);
        check("bandgap idle", bandgap_enable_o, 0);
        check("level", brownout_level_high_o, 0);
        bus(1, 4'h8, 32'h1);
        rdchk(4'h8, 32'h1, "acmp");
        check("bandgap select", bandgap_enable_o, 1);
        bus(1, 4'h8, 32'h0);
        // A write without byte lane zero is dropped
        sel_i <= 4'hE;
        bus(1, 4'h8, 32'h1);
        sel_i <= 4'hF;
        rdchk(4'h8, 32'h0, "lane dropped");
        adc_enable_i <= 1;
        repeat (3) @(posedge clk_i);
        check("bandgap adc", bandgap_enable_o, 1);
        adc_enable_i <= 0;
        $display("bandgap test done");
        // Shortest period is four scaled oscillator ticks of 124 cycles
        bus(1, 4'h4, 32'h08);
        n = 0;
        while (internal_reset_o !== 1'b1 && n < 700) begin
            @(posedge clk_i);
            n++;
        end
        check("expiry window", n > 360 && n < 520, 1);
        wait_low();
        rdchk(4'h0, 32'h08, "wdt flag");
        bus(1, 4'h0, 32'h0);
        rdchk(4'h4, 32'h0, "wdt cleared");
        bus(1, 4'h4, 32'h08);
        repeat (8) begin
            repeat (150) @(posedge clk_i);
            restart_i <= 1;
            @(posedge clk_i);
            restart_i <= 0;
        end
        rdchk(4'h0, 32'h0, "restart held off");
        bus(1, 4'h4, 32'h18);
        repeat (8) @(posedge clk_i);
        rdchk(4'h4, 32'h08, "toe self clear");
        bus(1, 4'h4, 32'h00);
        rdchk(4'h4, 32'h08, "plain clear kept");
        bus(1, 4'h4, 32'h18);
        bus(1, 4'h4, 32'h00);
        rdchk(4'h4, 32'h00, "protected off");
        repeat (1000) @(posedge clk_i);
        rdchk(4'h0, 32'h0, "disabled quiet");
        $display("watchdog test done");
        wrap_up();
    end
endmodule
